// >>> design/lcf_logic_cell.sv
// function generators, steering selectors and storage of one logic cell
`timescale 1ns/1ps

module lcf_logic_cell (
  input  wire logic             clk,        // 25 MHz cell clock
  input  wire logic             arst_n,     // asynchronous reset, active low
  input  wire logic             cfg_mode,   // high while the cell is configured
  input  wire logic             cfg_load,   // load strobe for cfg_word
  input  wire lcf_pkg::lcf_cfg_t cfg_word,  // configuration image to load
  input  wire lcf_pkg::lcf_cell_in_t cell_in, // routing inputs of the cell
  output logic                  x_comb,     // x combinational result, timed
  output logic                  y_comb,     // y combinational result, timed
  output logic                  x_q,        // x flip-flop output
  output logic                  y_q,        // y flip-flop output
  output logic                  cfg_loaded  // a configuration has been loaded
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // table lookup shared by all three tables
  function automatic logic tbl_read(input logic [15:0] tbl, input logic [3:0] idx);
    tbl_read = tbl[idx];
  endfunction : tbl_read

  // ---------------------------------------------------------------
  // configuration memory
  // ---------------------------------------------------------------
  lcf_pkg::lcf_cfg_t cfg_reg;               // held configuration image
  logic              loaded_reg;            // configuration present

  // contents only change while the cell is in configuration mode
  // load only in configuration
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reg <= lcf_pkg::CFG_RESET;
    end
    else if (cfg_mode && cfg_load)
    begin
      cfg_reg <= cfg_word;
    end
  end

  // loaded flag, kept once set; reconfiguration leaves it set
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loaded_reg <= lcf_pkg::OUT_RESET;
    end
    else if (cfg_mode && cfg_load)
    begin
      loaded_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // function generators
  // ---------------------------------------------------------------
  logic       first_out;                    // first quad table result
  logic       second_out;                   // second quad table result
  logic       comb_idx0;                    // combining index 0
  logic       comb_idx1;                    // combining index 1
  logic       comb_idx2;                    // combining index 2
  logic [3:0] comb_addr;                    // combining table address
  logic       comb_out;                     // combining table result

  assign first_out  = tbl_read(cfg_reg.first_tbl, cell_in.first_table_inputs);
  assign second_out = tbl_read(cfg_reg.second_tbl, cell_in.second_table_inputs);

  assign comb_idx0 = cfg_reg.idx0_from_table ? second_out : cell_in.set_reset_control;
  assign comb_idx2 = cfg_reg.idx2_from_table ? first_out : cell_in.direct_data;

  assign comb_idx1 = cell_in.combining_direct_input;

  // upper address bit tied low, so the 8 entries sit in the low half
  assign comb_addr = {1'b0, comb_idx2, comb_idx1, comb_idx0};

  assign comb_out = tbl_read({8'h00, cfg_reg.comb_tbl}, comb_addr);

  // ---------------------------------------------------------------
  // output steering
  // ---------------------------------------------------------------
  logic x_sel;                              // selected x result
  logic y_sel;                              // selected y result
  logic ffx_d;                              // x flip-flop data
  logic ffy_d;                              // y flip-flop data

  assign x_sel = cfg_reg.x_from_comb ? comb_out : first_out;
  assign y_sel = cfg_reg.y_from_comb ? comb_out : second_out;

  // four-way data source selector, shared by both flops
  function automatic logic ff_pick(input lcf_pkg::lcf_ff_src_t src,
                                   input logic f, input logic g,
                                   input logic h, input logic d);
    unique case (src)
      lcf_pkg::LCF_SRC_FIRST:  ff_pick = f;
      lcf_pkg::LCF_SRC_SECOND: ff_pick = g;
      lcf_pkg::LCF_SRC_COMB:   ff_pick = h;
      lcf_pkg::LCF_SRC_DIRECT: ff_pick = d;
    endcase
  endfunction : ff_pick

  assign ffx_d = ff_pick(cfg_reg.ffx_src, first_out, second_out, comb_out,
                         cell_in.direct_data);
  assign ffy_d = ff_pick(cfg_reg.ffy_src, first_out, second_out, comb_out,
                         cell_in.direct_data);

  // ---------------------------------------------------------------
  // combinational output timing
  // ---------------------------------------------------------------

  // the two unregistered results are retimed so top outputs leave a flop;
  // this adds one cycle of latency but keeps the cell boundary clean
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_comb <= lcf_pkg::OUT_RESET;
      y_comb <= lcf_pkg::OUT_RESET;
    end
    else
    begin
      x_comb <= x_sel;
      y_comb <= y_sel;
    end
  end

  // ---------------------------------------------------------------
  // storage flip-flops
  // ---------------------------------------------------------------

  // two storage flip-flops
  // set/reset wins over enable; taken at the clock edge in this one-clock build
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_q <= lcf_pkg::OUT_RESET;
      y_q <= lcf_pkg::OUT_RESET;
    end
    else if (cell_in.set_reset_control)
    begin
      x_q <= cfg_reg.ffx_set;
      y_q <= cfg_reg.ffy_set;
    end
    else if (cell_in.clock_enable)
    begin
      x_q <= ffx_d;
      y_q <= ffy_d;
    end
  end

  assign cfg_loaded = loaded_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // configuration strobe: mode and load high in the same cycle
  sequence cfg_write_s;
    cfg_mode && cfg_load;
  endsequence

  sequence operate_s;
    !cfg_mode [*2];
  endsequence

  first_lookup_a: assert property (
    !cfg_reg.x_from_comb |=> x_comb ==
      $past(cfg_reg.first_tbl[cell_in.first_table_inputs]))
    else $error("x result differs from first table entry");

  second_lookup_a: assert property (
    !cfg_reg.y_from_comb |=> y_comb ==
      $past(cfg_reg.second_tbl[cell_in.second_table_inputs]))
    else $error("y result differs from second table entry");

  comb_lookup_a: assert property (
    cfg_reg.x_from_comb |=> x_comb == $past(cfg_reg.comb_tbl[
      {comb_idx2, cell_in.combining_direct_input, comb_idx0}]))
    else $error("x result differs from combining table entry");

  // both selectors on cell inputs: address is set/reset, direct, data in that order
  idx_steer_a: assert property (
    !cfg_reg.idx0_from_table && !cfg_reg.idx2_from_table |->
      comb_out == cfg_reg.comb_tbl[{cell_in.direct_data, cell_in.combining_direct_input,
                                    cell_in.set_reset_control}])
    else $error("combining input selector wrong");

  // mixed selector settings, judged from the table results, not the steering wires
  direct_idx_a: assert property (
    cfg_reg.idx0_from_table != cfg_reg.idx2_from_table |->
      comb_out == cfg_reg.comb_tbl[{
        cfg_reg.idx2_from_table ? first_out : cell_in.direct_data,
        cell_in.combining_direct_input,
        cfg_reg.idx0_from_table ? second_out : cell_in.set_reset_control}])
    else $error("combining index 1 not from direct input");

  cfg_static_a: assert property (
    operate_s |-> $stable(cfg_reg))
    else $error("configuration changed during operation");

  cfg_takes_a: assert property (
    cfg_write_s |=> cfg_reg == $past(cfg_word) && cfg_loaded)
    else $error("configuration word not taken");

  y_comb_sel_a: assert property (
    cfg_reg.y_from_comb && $stable(cfg_reg) |=> y_comb == $past(comb_out))
    else $error("y selector not taking combining result");

  ff_hold_a: assert property (
    !cell_in.set_reset_control && !cell_in.clock_enable |=> $stable(x_q) && $stable(y_q))
    else $error("flip-flop changed without enable");

  ff_capture_a: assert property (
    !cell_in.set_reset_control && cell_in.clock_enable
      && cfg_reg.ffx_src == lcf_pkg::LCF_SRC_DIRECT |=> x_q == $past(cell_in.direct_data))
    else $error("x flip-flop missed direct data");

  ff_setreset_a: assert property (
    cell_in.set_reset_control |=> x_q == $past(cfg_reg.ffx_set)
      && y_q == $past(cfg_reg.ffy_set))
    else $error("set/reset value not applied");

  five_var_a: assert property (
    cfg_reg.idx0_from_table && cfg_reg.idx2_from_table |->
      comb_out == cfg_reg.comb_tbl[{first_out, cell_in.combining_direct_input, second_out}])
    else $error("five-variable composition wrong");

endmodule : lcf_logic_cell

// >>> design/lcf_pkg.sv
// shared types and constants for the logic cell function generators
package lcf_pkg;

  // ---------------------------------------------------------------
  // table sizes
  // ---------------------------------------------------------------
  localparam int QUAD_ENTRIES = 16;   // entries in each 4-input table
  localparam int COMB_ENTRIES = 8;    // entries in the combining table

  // ---------------------------------------------------------------
  // flip-flop data source selector codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCF_SRC_FIRST  = 2'h0,            // first quad table result
    LCF_SRC_SECOND = 2'h1,            // second quad table result
    LCF_SRC_COMB   = 2'h2,            // combining table result
    LCF_SRC_DIRECT = 2'h3             // direct data input
  } lcf_ff_src_t;

  // ---------------------------------------------------------------
  // configuration image of one logic cell
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] first_tbl;           // first quad table contents
    logic [15:0] second_tbl;          // second quad table contents
    logic [7:0]  comb_tbl;            // combining table contents
    logic        idx0_from_table;     // index 0: second table, else set/reset line
    logic        idx2_from_table;     // index 2: first table, else direct data
    logic        x_from_comb;         // x output: combining table, else first
    logic        y_from_comb;         // y output: combining table, else second
    lcf_ff_src_t ffx_src;             // data source of the x flip-flop
    lcf_ff_src_t ffy_src;             // data source of the y flip-flop
    logic        ffx_set;             // x flip-flop set/reset value
    logic        ffy_set;             // y flip-flop set/reset value
  } lcf_cfg_t;

  // ---------------------------------------------------------------
  // routing inputs of one logic cell
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] first_table_inputs;   // inputs of the first quad table
    logic [3:0] second_table_inputs;  // inputs of the second quad table
    logic       combining_direct_input; // dedicated combining input
    logic       set_reset_control;    // set/reset line, also combining index 0
    logic       direct_data;          // direct data, also combining index 2
    logic       clock_enable;         // storage enable, active high
  } lcf_cell_in_t;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam lcf_cfg_t CFG_RESET = '{
    first_tbl:       16'h0000,
    second_tbl:      16'h0000,
    comb_tbl:        8'h00,
    idx0_from_table: 1'b0,
    idx2_from_table: 1'b0,
    x_from_comb:     1'b0,
    y_from_comb:     1'b0,
    ffx_src:         LCF_SRC_FIRST,
    ffy_src:         LCF_SRC_SECOND,
    ffx_set:         1'b0,
    ffy_set:         1'b0
  };
  localparam logic OUT_RESET = 1'b0;  // every output after reset

endpackage : lcf_pkg

// >>> dv/lcf_route_model.sv
// routing model that carries bench requests onto the cell inputs
`timescale 1ns/1ps

module lcf_route_model (
  input  wire logic                  clk,     // cell clock
  input  wire logic                  arst_n,  // asynchronous reset, active low
  input  wire lcf_pkg::lcf_cell_in_t req,     // value the bench asks for
  output lcf_pkg::lcf_cell_in_t      cell_in  // value on the cell inputs
);
  // ---------------------------------------------------------------
  // routing stage
  // ---------------------------------------------------------------
  // registered so the cell inputs move just after an edge, never at it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cell_in <= '0;                          // quiet routing in reset
    else
      cell_in <= req;                         // fresh value each cycle
  end
endmodule : lcf_route_model

// >>> dv/tb_logic_cell_function_generators.sv
// self-checking bench for the logic cell function generators
`timescale 1ns/1ps

module tb_logic_cell_function_generators;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                  clk = 1'b0;          // 25 MHz cell clock
  logic                  arst_n = 1'b0;       // reset, active low
  logic                  cfg_mode = 1'b0;     // configuration phase
  logic                  cfg_load = 1'b0;     // load strobe
  lcf_pkg::lcf_cfg_t     cfg_word = '0;       // image to load
  lcf_pkg::lcf_cell_in_t req = '0;            // request to the routing model
  lcf_pkg::lcf_cell_in_t cell_in;             // routed cell inputs
  logic                  x_comb, y_comb, x_q, y_q, cfg_loaded; // design outputs
  lcf_pkg::lcf_cfg_t     cfg_reg;             // configuration in effect, bench view
  logic [4:0]            exp_q[$];            // {x_comb, y_comb, x_q, y_q, cfg_loaded}
  logic [4:0]            e;                   // newest prediction
  int                    n_fail = 0;          // mismatches
  int                    total_checks = 0;    // comparisons made
  int                    seed = 32'he499;     // fixed random seed

  always #20 clk = ~clk;

  lcf_logic_cell u_dut (.clk(clk), .arst_n(arst_n), .cfg_mode(cfg_mode), .cfg_load(cfg_load),
    .cfg_word(cfg_word), .cell_in(cell_in), .x_comb(x_comb), .y_comb(y_comb), .x_q(x_q),
    .y_q(y_q), .cfg_loaded(cfg_loaded));
  lcf_route_model u_route (.clk(clk), .arst_n(arst_n), .req(req), .cell_in(cell_in));

  // ---------------------------------------------------------------
  // reference of one cycle: tables, steering, storage
  // ---------------------------------------------------------------
  function automatic logic [4:0] predict(lcf_pkg::lcf_cfg_t c, lcf_pkg::lcf_cell_in_t i,
                                         logic [4:0] prev, logic ld);
    logic       f, g, h, i0, i2, xq, yq;
    logic [3:0] pick;
    f = c.first_tbl[i.first_table_inputs];
    g = c.second_tbl[i.second_table_inputs];
    i0 = c.idx0_from_table ? g : i.set_reset_control;
    i2 = c.idx2_from_table ? f : i.direct_data;
    h = c.comb_tbl[{i2, i.combining_direct_input, i0}];
    pick = {i.direct_data, h, g, f};          // indexed by the source code
    xq = prev[2];
    yq = prev[1];
    if (i.set_reset_control)
    begin
      xq = c.ffx_set;                         // set/reset wins over enable
      yq = c.ffy_set;
    end
    else if (i.clock_enable)
    begin
      xq = pick[c.ffx_src];
      yq = pick[c.ffy_src];
    end
    return {c.x_from_comb ? h : f, c.y_from_comb ? h : g, xq, yq, ld};
  endfunction : predict

  // ---------------------------------------------------------------
  // driver-side notes: one expectation per active edge
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reg = lcf_pkg::CFG_RESET;
      e = '0;
      exp_q.delete();                         // nothing in flight survives reset
    end
    else
    begin
      e = predict(cfg_reg, cell_in, e, e[0] | (cfg_mode & cfg_load));
      exp_q.push_back(e);
      // a load only takes effect for the next cycle's evaluation
      if (cfg_mode && cfg_load)
        cfg_reg = cfg_word;
    end
  end

  task automatic check(string what, logic [4:0] seen, logic [4:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, want, seen);
    end
  endtask : check

  // ---------------------------------------------------------------
  // monitor: results show one edge after their inputs, judged mid-cycle
  // ---------------------------------------------------------------
  always @(negedge clk)
  begin
    if (arst_n && exp_q.size() > 0)
      check("outputs", {x_comb, y_comb, x_q, y_q, cfg_loaded}, exp_q.pop_front());
  end

  task automatic cycles(int n);
    repeat (n)
    begin
      @(posedge clk);
      req <= 12'($random(seed));
      cfg_mode <= 1'b0;
      cfg_load <= 1'b0;
    end
  endtask : cycles

  task automatic load(lcf_pkg::lcf_cfg_t w, logic mode);
    @(posedge clk);
    cfg_mode <= mode;
    cfg_load <= 1'b1;
    cfg_word <= w;
  endtask : load

  function automatic lcf_pkg::lcf_cfg_t rnd_cfg(int k);
    lcf_pkg::lcf_cfg_t w;
    w = 50'({$random(seed), $random(seed)});  // the image is 50 bits wide
    w.ffx_src = lcf_pkg::lcf_ff_src_t'(k[1:0]);  // every source code in turn
    w.ffy_src = lcf_pkg::lcf_ff_src_t'(~k[1:0]);
    return w;
  endfunction : rnd_cfg

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    cycles(20);
    for (int k = 0; k < 8; k++)
    begin
      load(rnd_cfg(k), 1'b1);
      cycles(30);
    end
    load('{first_tbl: 16'h6996, second_tbl: 16'h6996, comb_tbl: 8'h96, idx0_from_table: 1'b1,
           idx2_from_table: 1'b1, x_from_comb: 1'b1, y_from_comb: 1'b0,
           ffx_src: lcf_pkg::LCF_SRC_COMB, ffy_src: lcf_pkg::LCF_SRC_DIRECT,
           ffx_set: 1'b1, ffy_set: 1'b0}, 1'b1);
    cycles(40);
    load(rnd_cfg(1), 1'b0);
    cycles(20);
    load(rnd_cfg(2), 1'b1);
    load(rnd_cfg(3), 1'b1);
    cycles(20);
    @(posedge clk);
    arst_n <= 1'b0;
    cycles(3);
    arst_n <= 1'b1;
    cycles(20);
    conclude();
  end

  // hang guard well beyond the few hundred cycles the sequence needs
  initial
  begin
    #(40 * 4000);
    n_fail++;
    conclude();
  end
endmodule : tb_logic_cell_function_generators
